// File: shared/rspc_pkg.sv
/*
 * Package for the reset and standby pin-state controller: constants, types
 * and the carrier structs shared by the controller, its checker and its bench.
 * Assumes a single 50 MHz clock; all pin groups are active-low where named _n.
 */
package rspc_pkg;
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam int PORT_W = 8;
	localparam int NUM_PORTS = 9;
	localparam int CLK_PERIOD_NS = 20;
	localparam int INIT_LEAD_CYCLES = 10;
	localparam int EXIT_LEAD_NS = 100;
	localparam int EXIT_LEAD_CYCLES = (EXIT_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAIT_PORT = 6;
	localparam int WAIT_BIT = 0;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 24'h000000;

	typedef enum logic [2:0] {
		RSPC_IDLE,
		RSPC_FIRST,
		RSPC_SECOND,
		RSPC_THIRD,
		RSPC_WAIT
	} rspc_bus_state_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic addr_oe;
		logic [DATA_W-1:0] data;
		logic data_oe;
		logic address_strobe_n;
		logic read_strobe_n;
		logic upper_byte_write_n;
		logic lower_byte_write_n;
	} rspc_bus_t;

	typedef struct packed {
		logic [NUM_PORTS*PORT_W-1:0] data;
		logic [NUM_PORTS*PORT_W-1:0] dir;
	} rspc_port_t;
endpackage

// File: hdl/rspc_addr_stage.sv
/*
 * Address output stage: holds or drives low the address bus when chip
 * initialization is taken, by the bus state in which it arrived.
 * Assumes init_taken is already sampled on the falling clock edge.
 */
`timescale 1ns/1ns
module rspc_addr_stage
	import rspc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Control
	input wire logic init_taken,
	input wire logic init_active,
	input wire logic standby,
	input wire rspc_pkg::rspc_bus_state_t bus_state,
	input wire logic two_state_area,
	input wire logic [rspc_pkg::ADDR_W-1:0] core_addr,
	input wire logic core_addr_oe,
	// Address now standing on the pins
	input wire logic [rspc_pkg::ADDR_W-1:0] pin_addr,
	input wire logic pin_addr_oe,
	// Next pin values; the pin flops of the top register them, so no extra stage
	output logic [rspc_pkg::ADDR_W-1:0] nxt_addr,
	output logic nxt_addr_oe
);
	logic hold_ff;
	logic nxt_hold;

	always_comb begin
		nxt_hold = 1'b0;
		nxt_addr = pin_addr;
		nxt_addr_oe = pin_addr_oe;
		if (standby) begin
			nxt_addr_oe = 1'b0;
		end else if (init_taken) begin
			// Third state, or last state of a two-state access, keeps the address
			if (bus_state == RSPC_THIRD ||
				(bus_state == RSPC_SECOND && two_state_area)) begin
				nxt_hold = 1'b1;
			end else begin
				// Half a state after the falling-edge sample is this rising edge
				nxt_addr = ADDR_RESET;
				nxt_addr_oe = 1'b1;
			end
		end else if (hold_ff) begin
			nxt_addr = ADDR_RESET;
			nxt_addr_oe = 1'b1;
		end else if (init_active) begin
			nxt_addr = ADDR_RESET;
			nxt_addr_oe = 1'b1;
		end else begin
			nxt_addr = core_addr;
			nxt_addr_oe = core_addr_oe;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hold_ff <= 1'b0;
		end else begin
			hold_ff <= nxt_hold;
		end
	end
endmodule

// File: hdl/rspc_top.sv
/*
 * Reset and standby pin-state controller: drives external bus and port pins
 * from the core's values, overriding them on chip initialization and
 * hardware standby. Assumes the core supplies its bus state every cycle and
 * the supervisor keeps the initialization/standby ordering.
 */
`timescale 1ns/1ns
module rspc_top
	import rspc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Supervisor pins
	input wire logic chip_init_n,
	input wire logic standby_request_n,
	// Core side
	input wire rspc_pkg::rspc_bus_state_t bus_state,
	input wire logic two_state_area,
	input wire rspc_pkg::rspc_bus_t core_bus,
	input wire rspc_pkg::rspc_port_t core_port,
	input wire logic onchip_ram_enable,
	// Pins
	output rspc_pkg::rspc_bus_t pin_bus_ff,
	output rspc_pkg::rspc_port_t pin_port_ff,
	output logic clk_out_oe_ff,
	output logic in_init_ff,
	output logic ram_retained_ff
);
	logic init_fall_ff;
	logic init_prev_ff;
	logic init_taken;
	logic standby;
	logic [ADDR_W-1:0] nxt_addr;
	logic nxt_addr_oe;
	rspc_bus_t nxt_bus;
	rspc_port_t nxt_port;
	logic nxt_ram_retained;
	logic [NUM_PORTS*PORT_W-1:0] core_dir_safe;

	// Sampled on the falling edge so the response can follow half a state later
	always_ff @(negedge clk or negedge reset_n) begin
		if (!reset_n) begin
			init_fall_ff <= 1'b0;
		end else begin
			init_fall_ff <= ~chip_init_n;
		end
	end

	assign init_taken = init_fall_ff & ~init_prev_ff;
	assign standby = ~standby_request_n;

	always_comb begin
		core_dir_safe = core_port.dir;
		// Wait input pin must never be an output, even if software asks
		core_dir_safe[WAIT_PORT*PORT_W+WAIT_BIT] = 1'b0;
	end

	rspc_addr_stage u_addr (
		.clk(clk),
		.reset_n(reset_n),
		.init_taken(init_taken),
		.init_active(init_fall_ff),
		.standby(standby),
		.bus_state(bus_state),
		.two_state_area(two_state_area),
		.core_addr(core_bus.addr),
		.core_addr_oe(core_bus.addr_oe),
		.pin_addr(pin_bus_ff.addr),
		.pin_addr_oe(pin_bus_ff.addr_oe),
		.nxt_addr(nxt_addr),
		.nxt_addr_oe(nxt_addr_oe)
	);

	always_comb begin
		nxt_bus = core_bus;
		nxt_port = core_port;
		nxt_port.dir = core_dir_safe;
		nxt_ram_retained = ram_retained_ff;
		if (standby) begin
			nxt_bus.data_oe = 1'b0;
			nxt_bus.address_strobe_n = 1'b1;
			nxt_bus.read_strobe_n = 1'b1;
			nxt_bus.upper_byte_write_n = 1'b1;
			nxt_bus.lower_byte_write_n = 1'b1;
			nxt_port.dir = '0;
			nxt_port.data = pin_port_ff.data;
			// Retention is valid if init led standby or RAM was off
			if (!ram_retained_ff) begin
				nxt_ram_retained = init_fall_ff | ~onchip_ram_enable;
			end
		end else if (init_fall_ff) begin
			nxt_bus.data_oe = 1'b0;
			nxt_bus.address_strobe_n = 1'b1;
			nxt_bus.read_strobe_n = 1'b1;
			nxt_bus.upper_byte_write_n = 1'b1;
			nxt_bus.lower_byte_write_n = 1'b1;
			nxt_port.dir = '0;
			nxt_port.data = pin_port_ff.data;
		end else begin
			// Leaving standby needs init held first; retention flag clears once standby and init are both released
			nxt_ram_retained = 1'b0;
		end
		// Address moves in the same cycle as the strobes, except one cycle later when init hits a holding state; one flop from the pin
		nxt_bus.addr = nxt_addr;
		nxt_bus.addr_oe = nxt_addr_oe;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			init_prev_ff <= 1'b0;
			pin_bus_ff <= '{addr: ADDR_RESET, addr_oe: 1'b0, data: '0, data_oe: 1'b0,
				address_strobe_n: 1'b1, read_strobe_n: 1'b1,
				upper_byte_write_n: 1'b1, lower_byte_write_n: 1'b1};
			pin_port_ff <= '0;
			clk_out_oe_ff <= 1'b0;
			in_init_ff <= 1'b0;
			ram_retained_ff <= 1'b0;
		end else begin
			init_prev_ff <= init_fall_ff;
			pin_bus_ff <= nxt_bus;
			pin_port_ff <= nxt_port;
			clk_out_oe_ff <= ~standby;
			in_init_ff <= init_fall_ff;
			ram_retained_ff <= nxt_ram_retained;
		end
	end
endmodule

// File: tb/rspc_checker.sv
/* Pin assertions for rspc_top; assumes the bind at the foot attaches it. */
`timescale 1ns/1ns
module rspc_checker
	import rspc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Inputs
	input wire logic chip_init_n,
	input wire logic standby_request_n,
	input wire rspc_pkg::rspc_bus_state_t bus_state,
	input wire logic two_state_area,
	// Pins
	input wire rspc_pkg::rspc_bus_t pin_bus_ff,
	input wire rspc_pkg::rspc_port_t pin_port_ff,
	input wire logic clk_out_oe_ff,
	input wire logic in_init_ff
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic go, hold;
	// First low sample only; later samples keep the already driven state
	assign go = !chip_init_n && standby_request_n && !in_init_ff;
	assign hold = bus_state == RSPC_THIRD || (bus_state == RSPC_SECOND && two_state_area);
	property p_dir; !chip_init_n |=> pin_port_ff.dir == '0; endproperty
	a_dir: assert property (p_dir) else $error("ports not input");
	property p_stb; !chip_init_n |=> pin_bus_ff[4:0] == 5'h0f; endproperty
	a_stb: assert property (p_stb) else $error("strobes or data");
	property p_low; go && !hold |=> pin_bus_ff.addr == '0 && pin_bus_ff.addr_oe; endproperty
	a_low: assert property (p_low) else $error("addr not low");
	property p_hold; go && hold |=> $stable(pin_bus_ff.addr) ##1 pin_bus_ff.addr == '0;
	endproperty
	a_hold: assert property (p_hold) else $error("addr not held");
	property p_smp; standby_request_n ##1 standby_request_n |-> in_init_ff == !$past(chip_init_n);
	endproperty
	a_smp: assert property (p_smp) else $error("init sample");
	property p_keep; in_init_ff && !chip_init_n |=> $stable(pin_port_ff.data); endproperty
	a_keep: assert property (p_keep) else $error("port data moved");
	property p_standby_request_n; !standby_request_n |=> !clk_out_oe_ff && !pin_bus_ff.addr_oe
		&& !pin_bus_ff.data_oe && pin_port_ff.dir == '0; endproperty
	a_standby_request_n: assert property (p_standby_request_n) else $error("pins driven in standby");
	property p_wait; pin_port_ff.dir[WAIT_PORT*PORT_W+WAIT_BIT] == 1'b0; endproperty
	a_wait: assert property (p_wait) else $error("wait pin output");
endmodule
bind rspc_top rspc_checker rspc_checker_i (.clk(clk), .reset_n(reset_n),
	.chip_init_n(chip_init_n), .standby_request_n(standby_request_n), .bus_state(bus_state),
	.two_state_area(two_state_area), .pin_bus_ff(pin_bus_ff), .pin_port_ff(pin_port_ff),
	.clk_out_oe_ff(clk_out_oe_ff), .in_init_ff(in_init_ff));

// File: tb/rspc_supervisor.sv
/* Reset and standby supervisor model; tasks are called from the bench at posedge. */
`timescale 1ns/1ns
module rspc_supervisor
	import rspc_pkg::*;
(
	// Clock
	input wire logic clk,
	// Supervisor pins
	output logic chip_init_n,
	output logic standby_request_n
);
	initial begin
		chip_init_n = 1'b1;
		standby_request_n = 1'b1;
	end
	task automatic init_for(input int n);
		chip_init_n <= 1'b0;
		repeat (n) @(posedge clk);
		chip_init_n <= 1'b1;
	endtask
	task automatic standby(input logic ram_en);
		chip_init_n <= !ram_en;
		if (ram_en)
			repeat (INIT_LEAD_CYCLES) @(posedge clk);
		standby_request_n <= 1'b0;
		repeat (8) @(posedge clk);
		chip_init_n <= 1'b0;
		repeat (EXIT_LEAD_CYCLES) @(posedge clk);
		standby_request_n <= 1'b1;
		repeat (2) @(posedge clk);
		chip_init_n <= 1'b1;
	endtask
endmodule

// File: tb/tb.sv
/* Self-checking bench for rspc_top; the supervisor model drives init and standby. */
`timescale 1ns/1ns
module tb;
	import rspc_pkg::*;
	logic clk, reset_n, two_state_area, onchip_ram_enable, chip_init_n, standby_request_n;
	logic clk_out_oe_ff, in_init_ff, ram_retained_ff;
	rspc_bus_state_t bus_state;
	rspc_bus_t core_bus, pin_bus_ff;
	rspc_port_t core_port, pin_port_ff;
	int error_cnt, cmp_count, cyc;
	logic [ADDR_W-1:0] a0;
	rspc_top rspc_top_i (.clk(clk), .reset_n(reset_n), .chip_init_n(chip_init_n),
		.standby_request_n(standby_request_n), .bus_state(bus_state),
		.two_state_area(two_state_area), .core_bus(core_bus), .core_port(core_port),
		.onchip_ram_enable(onchip_ram_enable), .pin_bus_ff(pin_bus_ff),
		.pin_port_ff(pin_port_ff), .clk_out_oe_ff(clk_out_oe_ff), .in_init_ff(in_init_ff),
		.ram_retained_ff(ram_retained_ff));
	rspc_supervisor rspc_supervisor_i (.clk(clk), .chip_init_n(chip_init_n),
		.standby_request_n(standby_request_n));
	task automatic check(input logic [NUM_PORTS*PORT_W-1:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	function automatic logic held(input rspc_bus_state_t s, input logic two);
		return s == RSPC_THIRD || (s == RSPC_SECOND && two);
	endfunction
	task automatic print_verdict();
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic init_case(input rspc_bus_state_t s, input logic two);
		core_bus <= $bits(rspc_bus_t)'({$urandom, $urandom});
		core_port <= $bits(rspc_port_t)'({$urandom, $urandom, $urandom, $urandom, $urandom});
		@(posedge clk);
		bus_state <= s;
		two_state_area <= two;
		fork
			rspc_supervisor_i.init_for(4);
			begin
				#1 a0 = pin_bus_ff.addr;
				check(pin_bus_ff, core_bus);
				check(pin_port_ff.dir, core_port.dir & ~(72'h1 << (WAIT_PORT*PORT_W+WAIT_BIT)));
				@(posedge clk) #1;
				check(pin_port_ff.dir, '0);
				check(pin_bus_ff[4:0], 5'h0f);
				check(pin_bus_ff.addr, held(s, two) ? a0 : '0);
				@(posedge clk) #1;
				check(pin_bus_ff.addr, '0);
			end
		join
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Cuts a hang short well above the roughly 300 cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc > 3000) begin
			error_cnt++;
			print_verdict();
		end
	end
	initial begin
		reset_n = 1'b0;
		bus_state = RSPC_IDLE;
		two_state_area = 1'b0;
		core_bus = '0;
		core_port = '0;
		onchip_ram_enable = 1'b0;
		void'($urandom(32'h569e));
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 10; i++)
			init_case(rspc_bus_state_t'(i % 5), i > 4);
		repeat (40)
			init_case(rspc_bus_state_t'($urandom_range(4)), 1'($urandom));
		for (int r = 0; r < 2; r++) begin
			@(posedge clk);
			onchip_ram_enable <= r[0];
			fork
				rspc_supervisor_i.standby(r[0]);
				begin
					repeat (r ? 14 : 4) @(posedge clk);
					#1 check({clk_out_oe_ff, pin_bus_ff.addr_oe, ram_retained_ff}, 3'h1);
					check(pin_port_ff.dir, '0);
				end
			join
		end
		print_verdict();
	end
endmodule
